// [core/iocc_defs.svh]
`ifndef IOCC_DEFS_SVH
`define IOCC_DEFS_SVH

// Register map
`define IOCC_ADDR_CLOCK_CONFIGURATION 8'hf8
`define IOCC_ADDR_PROC_STATUS 8'hff
`define IOCC_RESET_CLOCK_CONFIGURATION 8'h00
`define IOCC_RESET_PROC_STATUS 8'h00
`define IOCC_RESET_VECTOR 13'h0000

// Clock configuration fields
`define IOCC_BIT_RESUME_DELAY 7
`define IOCC_BIT_WAKE_HI 6
`define IOCC_BIT_WAKE_LO 4
`define IOCC_BIT_LVR_DISABLE 3
`define IOCC_BIT_USB_TUNE 2
`define IOCC_BIT_CLKOUT_DISABLE 1
`define IOCC_BIT_EXT_OSC 0

// Timing
`define IOCC_CLK_MHZ 125
`define IOCC_DELAY_LONG_US 4000
`define IOCC_DELAY_SHORT_US 128
`define IOCC_DELAY_INT_US 9
`define IOCC_SETTLE_US 200
`define IOCC_WAKE_BASE_US 1000

`endif

// [core/iocc_pkg.sv]
package iocc_pkg;
    typedef enum logic [3:0] {
        IOCC_RUN = 4'h1,
        IOCC_OSC_START = 4'h2,
        IOCC_RESUME = 4'h4,
        IOCC_SETTLE = 4'h8
    } iocc_state_t;
endpackage : iocc_pkg

// [core/iocc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module iocc_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Asynchronous in, synchronous out
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : iocc_sync
`default_nettype wire

// [core/iocc_io_clock.sv]
// Summary of operation
// RULE1 - I/O read returns the addressed register value into the accumulator.
// RULE2 - I/O write stores the accumulator into the register named by the address.
// RULE3 - Indexed write address is index register plus instruction address field.
// RULE4 - Indexed write with zero address field selects by index register alone.
// RULE5 - Reset clears all I/O registers except processor status and control.
// RULE6 - Firmware never writes unassigned I/O addresses.
// RULE7 - Reserved bits written zero; reads of them are undefined.
// RULE8 - Clock configuration is an 8-bit read/write register at address 0xf8.
// RULE9 - Bit 7 picks 4 ms or 128 us external clock resume delay.
// RULE10 - Internal oscillator wake uses only about 9 us delay.
// RULE11 - Bits 6..4 set the wake-up timer period for periodic wake events.
// RULE12 - Bit 3 set disables low-voltage reset, clear keeps it enabled.
// RULE13 - Enabled low-voltage event holds partial suspend, then restarts at 0x0000.
// RULE14 - Setting bit 0 halts while external oscillator starts; clearing waits for wake.
// RULE15 - Bit 1 set holds oscillator output high, else internal clock drives it; in external mode the code holds the pin low.
// RULE16 - Bit 2 enables USB fine tuning in internal mode after USB traffic.
// RULE17 - Wake-up period mapping of the adjust bits is a parameter.
// RULE18 - Indexed write address sum is truncated to eight bits.
`timescale 1ns/1ps
`default_nettype none
`include "iocc_defs.svh"
module iocc_io_clock
    import iocc_pkg::*;
#(
    parameter int unsigned LONG_CYCLES = `IOCC_DELAY_LONG_US * `IOCC_CLK_MHZ,
    parameter int unsigned SHORT_CYCLES = `IOCC_DELAY_SHORT_US * `IOCC_CLK_MHZ,
    parameter int unsigned INT_CYCLES = `IOCC_DELAY_INT_US * `IOCC_CLK_MHZ,
    parameter int unsigned SETTLE_CYCLES = `IOCC_SETTLE_US * `IOCC_CLK_MHZ,
    parameter int unsigned WAKE_BASE_CYCLES = `IOCC_WAKE_BASE_US * `IOCC_CLK_MHZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // CPU I/O access
    input wire logic io_read_instr,
    input wire logic io_write_instr,
    input wire logic io_indexed_write_instr,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] accumulator,
    output logic [7:0] read_data,
    output logic read_valid,
    // Processor status register access to external storage
    input wire logic [7:0] proc_status_in,
    output logic proc_status_we,
    output logic [7:0] proc_status_out,
    // Events from the chip
    input wire logic low_voltage_threshold,
    input wire logic suspend_wake,
    input wire logic ext_osc_stable,
    input wire logic usb_traffic,
    input wire logic wake_irq_enable,
    input wire logic internal_clk,
    // Clock control outputs
    output logic cpu_halt,
    output logic cpu_restart,
    output logic [12:0] restart_vector,
    output logic ext_osc_on,
    output logic oscillator_output_pin,
    output logic usb_tune_en,
    output logic low_voltage_reset,
    output logic wake_event
);
    logic [7:0] clock_configuration;
    logic [7:0] target_addr;
    logic wr_any;
    logic lv_s, wake_s, stable_s, usb_s, clk_s;
    logic ext_mode;
    logic tuned;
    iocc_state_t state;
    logic [31:0] dly_cnt;
    logic [31:0] wake_cnt;
    logic [31:0] wake_period;

    iocc_sync u_lv (.ref_clk(ref_clk), .sys_rst(sys_rst), .d(low_voltage_threshold), .q(lv_s));
    iocc_sync u_wk (.ref_clk(ref_clk), .sys_rst(sys_rst), .d(suspend_wake), .q(wake_s));
    iocc_sync u_st (.ref_clk(ref_clk), .sys_rst(sys_rst), .d(ext_osc_stable), .q(stable_s));
    iocc_sync u_us (.ref_clk(ref_clk), .sys_rst(sys_rst), .d(usb_traffic), .q(usb_s));
    iocc_sync u_ck (.ref_clk(ref_clk), .sys_rst(sys_rst), .d(internal_clk), .q(clk_s));

    // Address formation
    always_comb begin
        if (io_indexed_write_instr) begin
            target_addr = 8'(index_reg + io_addr); // [RULE3] [RULE4] [RULE18]
        end else begin
            target_addr = io_addr;
        end
        wr_any = io_write_instr | io_indexed_write_instr;
    end

    // Clock configuration register
    always_ff @(posedge ref_clk) begin
        if (sys_rst || (state == IOCC_SETTLE)) begin
            clock_configuration <= `IOCC_RESET_CLOCK_CONFIGURATION; // [RULE5]
        end else if (wr_any && target_addr == `IOCC_ADDR_CLOCK_CONFIGURATION) begin
            clock_configuration <= accumulator; // [RULE2] [RULE8]
        end
    end

    // Processor status write path
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            proc_status_we <= 1'b0;
            proc_status_out <= `IOCC_RESET_PROC_STATUS;
        end else begin
            proc_status_we <= wr_any && target_addr == `IOCC_ADDR_PROC_STATUS; // [RULE2]
            proc_status_out <= accumulator;
        end
    end

    // Read path
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            read_data <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= io_read_instr;
            if (io_read_instr) begin
                case (io_addr)
                    `IOCC_ADDR_CLOCK_CONFIGURATION: read_data <= clock_configuration; // [RULE1] [RULE8]
                    `IOCC_ADDR_PROC_STATUS: read_data <= proc_status_in; // [RULE1]
                    default: read_data <= 8'h00; // [RULE7]
                endcase
            end
        end
    end

    // Clock sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= IOCC_RUN;
            dly_cnt <= 32'h0;
            ext_mode <= 1'b0;
        end else if (lv_s && !clock_configuration[`IOCC_BIT_LVR_DISABLE] &&
                     state != IOCC_SETTLE) begin // [RULE12] [RULE13]
            state <= IOCC_SETTLE;
            dly_cnt <= SETTLE_CYCLES;
            ext_mode <= 1'b0;
        end else begin
            case (state)
                IOCC_RUN: begin
                    if (wr_any && target_addr == `IOCC_ADDR_CLOCK_CONFIGURATION &&
                                 accumulator[`IOCC_BIT_EXT_OSC] && !ext_mode) begin
                        state <= IOCC_OSC_START; // [RULE14]
                    end else if (wake_s) begin
                        ext_mode <= clock_configuration[`IOCC_BIT_EXT_OSC]; // [RULE14]
                        state <= IOCC_RESUME;
                        if (clock_configuration[`IOCC_BIT_EXT_OSC]) begin
                            dly_cnt <= clock_configuration[`IOCC_BIT_RESUME_DELAY] ? LONG_CYCLES
                                                                                  : SHORT_CYCLES; // [RULE9]
                        end else begin
                            dly_cnt <= INT_CYCLES; // [RULE10]
                        end
                    end
                end
                IOCC_OSC_START: begin
                    if (stable_s) begin
                        ext_mode <= 1'b1;
                        state <= IOCC_RESUME;
                        dly_cnt <= clock_configuration[`IOCC_BIT_RESUME_DELAY] ? LONG_CYCLES
                                                                              : SHORT_CYCLES; // [RULE9]
                    end
                end
                IOCC_RESUME, IOCC_SETTLE: begin
                    if (dly_cnt <= 32'h1) begin
                        state <= IOCC_RUN;
                    end else begin
                        dly_cnt <= dly_cnt - 32'h1;
                    end
                end
                default: state <= IOCC_RUN;
            endcase
        end
    end

    // Halt, restart and oscillator outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cpu_halt <= 1'b0;
            cpu_restart <= 1'b0;
            restart_vector <= `IOCC_RESET_VECTOR;
            ext_osc_on <= 1'b0;
            low_voltage_reset <= 1'b0;
            oscillator_output_pin <= 1'b0;
        end else begin
            cpu_halt <= (state != IOCC_RUN); // [RULE14]
            cpu_restart <= (state == IOCC_SETTLE) && (dly_cnt <= 32'h1); // [RULE13]
            restart_vector <= `IOCC_RESET_VECTOR;
            low_voltage_reset <= (state == IOCC_SETTLE);
            ext_osc_on <= ext_mode || (state == IOCC_OSC_START);
            if (ext_mode || state == IOCC_OSC_START) begin
                oscillator_output_pin <= 1'b0;
            end else begin
                oscillator_output_pin <= clock_configuration[`IOCC_BIT_CLKOUT_DISABLE] | clk_s; // [RULE15]
            end
        end
    end

    // USB fine tuning
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ext_mode || !clock_configuration[`IOCC_BIT_USB_TUNE]) begin
            tuned <= 1'b0;
            usb_tune_en <= 1'b0;
        end else begin
            if (usb_s) begin
                tuned <= 1'b1;
            end
            usb_tune_en <= tuned; // [RULE16]
        end
    end

    // Wake-up timer
    always_comb begin
        wake_period = 32'(WAKE_BASE_CYCLES << clock_configuration[`IOCC_BIT_WAKE_HI:`IOCC_BIT_WAKE_LO]); // [RULE17]
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !wake_irq_enable) begin
            wake_cnt <= 32'h0;
            wake_event <= 1'b0;
        end else if (wake_cnt + 32'h1 >= wake_period) begin
            wake_cnt <= 32'h0;
            wake_event <= 1'b1; // [RULE11]
        end else begin
            wake_cnt <= wake_cnt + 32'h1;
            wake_event <= 1'b0;
        end
    end
endmodule : iocc_io_clock
`default_nettype wire

// [tb/iocc_io_clock_props.sv]
`timescale 1ns/1ps
`default_nettype none
module iocc_io_clock_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // CPU side
    input wire logic io_read_instr,
    input wire logic io_write_instr,
    input wire logic io_indexed_write_instr,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] accumulator,
    // Answers
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic proc_status_we,
    input wire logic [7:0] proc_status_out,
    input wire logic cpu_halt,
    input wire logic cpu_restart,
    input wire logic [12:0] restart_vector,
    input wire logic ext_osc_on,
    input wire logic low_voltage_reset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_READ_VALID: assert property (io_read_instr |=> read_valid) else $error("read unanswered");
    AST_READ_ZERO: assert property (
        io_read_instr && io_addr != 8'hf8 && io_addr != 8'hff |=> read_data == 8'h00)
        else $error("unmapped read not zero");
    AST_WR_RD: assert property (
        io_write_instr && io_addr == 8'hf8 ##1 !io_write_instr && !io_indexed_write_instr
        ##1 io_read_instr && io_addr == 8'hf8 |=> read_data == $past(accumulator, 3)) else $error("config lost");
    AST_STATUS_WR: assert property (io_write_instr && io_addr == 8'hff |=> proc_status_we
        && proc_status_out == $past(accumulator)) else $error("status write lost");
    AST_INDEXED: assert property (
        io_indexed_write_instr && 8'(io_addr + index_reg) == 8'hff |=> proc_status_we)
        else $error("indexed address wrong");
    AST_RESTART: assert property ($rose(cpu_restart) |-> restart_vector == 13'h0000 && $past(low_voltage_reset))
        else $error("restart wrong");
    AST_LV_HALT: assert property (low_voltage_reset |-> cpu_halt) else $error("settle not halted");
    AST_EXT_HALT: assert property (
        io_write_instr && io_addr == 8'hf8 && accumulator[0] && !cpu_halt && !ext_osc_on |-> ##2 cpu_halt)
        else $error("no halt on external");
    AST_RST_CLEAN: assert property ($fell(sys_rst) |-> !cpu_halt && !read_valid && !proc_status_we)
        else $error("dirty after reset");
endmodule : iocc_io_clock_chk
bind iocc_io_clock iocc_io_clock_chk u_chk (.ref_clk, .sys_rst, .io_read_instr, .io_write_instr,
    .io_indexed_write_instr, .io_addr, .index_reg, .accumulator, .read_data, .read_valid, .proc_status_we,
    .proc_status_out, .cpu_halt, .cpu_restart, .restart_vector, .ext_osc_on, .low_voltage_reset);
`default_nettype wire

// [tb/iocc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module iocc_cpu_model (
    // Clock
    input wire logic ref_clk,
    // Instruction strobes and operands
    output logic io_read_instr,
    output logic io_write_instr,
    output logic io_indexed_write_instr,
    output logic [7:0] io_addr,
    output logic [7:0] index_reg,
    output logic [7:0] accumulator
);
    initial {io_read_instr, io_write_instr, io_indexed_write_instr, io_addr, index_reg, accumulator} = '0;
    // One instruction: k = {indexed write, write, read}
    task automatic op(input logic [2:0] k, input logic [7:0] a, input logic [7:0] x, input logic [7:0] d);
        logic [7:0] t;
        t = k[2] ? 8'(a + x) : a;
        @(posedge ref_clk);
        {io_indexed_write_instr, io_write_instr, io_read_instr} <=
            (k[0] || t == 8'hf8 || t == 8'hff) ? k : 3'b000;
        io_addr <= a;
        index_reg <= x;
        accumulator <= d;
        @(posedge ref_clk);
        {io_indexed_write_instr, io_write_instr, io_read_instr} <= 3'b000;
        io_addr <= ~a;
    endtask : op
endmodule : iocc_cpu_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic io_read_instr, io_write_instr, io_indexed_write_instr, read_valid, proc_status_we, cpu_halt, cpu_restart;
    logic ext_osc_on, oscillator_output_pin, usb_tune_en, low_voltage_reset, wake_event;
    logic low_voltage_threshold = 0, suspend_wake = 0, ext_osc_stable = 0, usb_traffic = 0;
    logic wake_irq_enable = 0, internal_clk = 0;
    logic [7:0] io_addr, index_reg, accumulator, read_data, proc_status_out, d, x;
    logic [7:0] proc_status_in = 8'h3c;
    logic [12:0] restart_vector;
    logic [7:0] q[$];
    int bad_count = 0, n_tests = 0, cnt, seed = 32'h3f656157;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) internal_clk <= ~internal_clk;
    iocc_cpu_model cpu (.ref_clk, .io_read_instr, .io_write_instr, .io_indexed_write_instr, .io_addr, .index_reg,
        .accumulator);
    iocc_io_clock #(.LONG_CYCLES(20), .SHORT_CYCLES(8), .INT_CYCLES(4), .SETTLE_CYCLES(12), .WAKE_BASE_CYCLES(6))
    dut (.ref_clk, .sys_rst, .io_read_instr, .io_write_instr, .io_indexed_write_instr, .io_addr, .index_reg,
        .accumulator, .read_data, .read_valid, .proc_status_in, .proc_status_we, .proc_status_out,
        .low_voltage_threshold, .suspend_wake, .ext_osc_stable, .usb_traffic, .wake_irq_enable, .internal_clk,
        .cpu_halt, .cpu_restart, .restart_vector, .ext_osc_on, .oscillator_output_pin, .usb_tune_en,
        .low_voltage_reset, .wake_event);
    task end_sim;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic logic sel(input int k);
        case (k)
            0: sel = cpu_halt;
            1: sel = low_voltage_reset;
            2: sel = cpu_restart;
            3: sel = wake_event;
            default: sel = usb_tune_en;
        endcase
    endfunction : sel
    // Bounded wait, cnt holds cycles spent
    task wait_v(input int k, input logic v);
        for (cnt = 0; cnt < 400 && sel(k) !== v; cnt++) @(posedge ref_clk);
        if (sel(k) !== v) begin
            bad_count++;
            end_sim;
        end
    endtask : wait_v
    task wr(input logic [7:0] a, input logic [7:0] v);
        cpu.op(3'b010, a, 8'h00, v);
    endtask : wr
    task rdq(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        cpu.op(3'b001, a, 8'h00, 8'h00);
    endtask : rdq
    // Read monitor
    always @(posedge ref_clk) if (read_valid === 1'b1) check("read_data", read_data, q.pop_front());
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdq(8'hf8, 8'h00);
        repeat (4) begin
            d = $random(seed) & 8'hfe;
            wr(8'hf8, d);
            rdq(8'hf8, d);
        end
        x = $random(seed);
        d = $random(seed) & 8'hfe;
        cpu.op(3'b100, 8'hf8 - x, x, d);
        rdq(8'hf8, d);
        cpu.op(3'b100, 8'h00, 8'hf8, 8'h5a);
        rdq(8'hf8, 8'h5a);
        cpu.op(3'b100, 8'h7f, 8'h80, 8'h21);
        wr(8'hff, 8'h42);
        @(posedge ref_clk);
        check("status_out", {proc_status_we, proc_status_out}, {1'b1, 8'h42});
        rdq(8'hff, 8'h3c);
        rdq(8'h40, 8'h00);
        wr(8'hf8, 8'h02);
        repeat (4) @(posedge ref_clk);
        check("clk_out_high", oscillator_output_pin, 1);
        @(posedge ref_clk);
        check("clk_out_high", oscillator_output_pin, 1);
        wr(8'hf8, 8'h04);
        repeat (2) @(posedge ref_clk);
        d[0] = oscillator_output_pin;
        @(posedge ref_clk);
        check("clk_out_run", oscillator_output_pin, !d[0]);
        usb_traffic <= 1'b1;
        wait_v(4, 1);
        wr(8'hf8, 8'h10);
        wake_irq_enable <= 1'b1;
        wait_v(3, 1);
        @(posedge ref_clk);
        wait_v(3, 1);
        check("wake_period", cnt, 11);
        wake_irq_enable <= 1'b0;
        ext_osc_stable <= 1'b1;
        wr(8'hf8, 8'h01);
        wait_v(0, 1);
        wait_v(0, 0);
        check("resume_delay", cnt >= 8 && cnt < 20, 1);
        check("ext_on", ext_osc_on, 1);
        check("pin_ext", oscillator_output_pin, 0);
        wr(8'hf8, 8'h81);
        suspend_wake <= 1'b1;
        wait_v(0, 1);
        suspend_wake <= 1'b0;
        wait_v(0, 0);
        check("long_delay", cnt >= 20, 1);
        wr(8'hf8, 8'h00);
        repeat (3) @(posedge ref_clk);
        check("ext_hold", ext_osc_on, 1);
        suspend_wake <= 1'b1;
        wait_v(0, 1);
        suspend_wake <= 1'b0;
        wait_v(0, 0);
        check("int_wake", {ext_osc_on, cnt < 8}, 2'b01);
        wr(8'hf8, 8'h08);
        low_voltage_threshold <= 1'b1;
        repeat (6) @(posedge ref_clk);
        low_voltage_threshold <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("lv_disabled", {low_voltage_reset, cpu_halt}, 2'b00);
        wr(8'hf8, 8'hf6);
        low_voltage_threshold <= 1'b1;
        wait_v(1, 1);
        low_voltage_threshold <= 1'b0;
        wait_v(2, 1);
        check("restart_vector", restart_vector, 13'h0000);
        rdq(8'hf8, 8'h00);
        repeat (4) @(posedge ref_clk);
        end_sim;
    end
endmodule : tb
`default_nettype wire
